// ### rtl/cic_top.sv
// codec interrupt controller: event latching, masking, polarity and registers
`timescale 1ns/100ps

//Behaviour
// R1 - output is OR of unmasked latched flags
// R2 - flags latch until status register read
// R3 - still-active source sets flag again after read
// R4 - output active high; control bit 0 inverts
// R5 - status bits 15,14,13 and 4..0, reset 0
// R6 - mask mirrors status, 1 masks, resets 1
// R7 - polarity bits 15,14 invert detector events
// R8 - sequencer finishing sets done flag
// R9 - pin event polarity follows pin configuration
// R10 - irq selectable on five pins, pin4 default
// R11 - status readable at any time
// R12 - function code 02h routes irq to pin
// R13 - read clears only returned bits, events kept
module cic_top #(
	parameter logic [5:0] PIN123_FN_RESET = 6'h00
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	// register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	output logic             REG_RVALID,
	// event sources
	input  wire logic [4:0]  GPIO_IN,
	input  wire logic [4:0]  PIN_INPUT_POLARITY,
	input  wire logic        BIAS_SHORT_DET,
	input  wire logic        BIAS_CURRENT_DET,
	input  wire logic        SEQ_BUSY,
	// interrupt output
	output logic             IRQ_OUT,
	output logic      [4:0]  PIN_IRQ_OUT,
	output logic      [4:0]  PIN_IRQ_OE
);

	// ***************************************************************
	// declarations
	// ***************************************************************
	logic [15:0]     status_reg;
	logic [15:0]     status_next;
	logic [15:0]     mask_reg;
	logic [15:0]     polarity_reg;
	logic [15:0]     control_reg;
	logic [4:0][5:0] pin_fn_reg;
	logic            seq_busy_q_reg;
	logic            irq_out_reg;
	logic            irq_out_next;
	logic [15:0]     rdata_reg;
	logic            rvalid_reg;

	logic [15:0]     set_vec;
	logic [15:0]     rd_mux;
	logic [5:0]      pin_fn_rd;
	logic [4:0]      pin_hit;
	logic [4:0]      pin_ev;
	logic            short_ev;
	logic            current_ev;
	logic            seq_done_ev;
	logic            short_detect_invert;
	logic            current_detect_invert;
	logic            irq_output_invert;
	logic            irq_raw;

	logic            hit_status;
	logic            hit_mask;
	logic            hit_polarity;
	logic            hit_control;
	logic            rd_status;
	logic            wr_mask;
	logic            wr_polarity;
	logic            wr_control;

	cic_if bus ();

	// ***************************************************************
	// address decode
	// ***************************************************************
	assign hit_status   = REG_ADDR == cic_pkg::EVENT_STATUS_ADDR;
	assign hit_mask     = REG_ADDR == cic_pkg::EVENT_MASK_ADDR;
	assign hit_polarity = REG_ADDR == cic_pkg::DETECTOR_POLARITY_ADDR;
	assign hit_control  = REG_ADDR == cic_pkg::IRQ_OUTPUT_CONTROL_ADDR;

	// status may be read at any moment, no lockout
	assign rd_status   = REG_RD && hit_status; // R11
	assign wr_mask     = REG_WR && hit_mask;
	assign wr_polarity = REG_WR && hit_polarity;
	assign wr_control  = REG_WR && hit_control;

	// ***************************************************************
	// event sources
	// ***************************************************************
	assign short_detect_invert   = polarity_reg[cic_pkg::SHORT_INVERT_BIT];
	assign current_detect_invert = polarity_reg[cic_pkg::CURRENT_INVERT_BIT];
	assign irq_output_invert     = control_reg[cic_pkg::IRQ_INVERT_BIT];

	// detector inputs are high above threshold; invert makes the low level the event
	assign short_ev   = BIAS_SHORT_DET ^ short_detect_invert; // R7
	assign current_ev = BIAS_CURRENT_DET ^ current_detect_invert; // R7

	// finishing means busy has just dropped
	assign seq_done_ev = seq_busy_q_reg && !SEQ_BUSY; // R8

	// polarity bit 1 means active high, 0 active low
	assign pin_ev = ~(GPIO_IN ^ PIN_INPUT_POLARITY); // R9

	assign set_vec = {short_ev, current_ev, seq_done_ev, 8'h00, pin_ev}; // R5

	// ***************************************************************
	// status latch
	// ***************************************************************
	// a set in the read cycle wins, so no event is lost
	assign status_next = ((rd_status ? 16'h0000 : status_reg) | set_vec)
		& cic_pkg::EVENT_BITS; // R2 R3 R13

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			status_reg     <= cic_pkg::STATUS_RESET; // R5
			seq_busy_q_reg <= 1'h0;
		end else begin
			status_reg     <= status_next; // R2
			seq_busy_q_reg <= SEQ_BUSY;
		end
	end

	// ***************************************************************
	// configuration registers
	// ***************************************************************
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			mask_reg     <= cic_pkg::MASK_RESET; // R6
			polarity_reg <= cic_pkg::POLARITY_RESET;
			control_reg  <= cic_pkg::CONTROL_RESET; // R4
		end else begin
			if (wr_mask) begin
				mask_reg <= REG_WDATA & cic_pkg::EVENT_BITS; // R6
			end
			if (wr_polarity) begin
				polarity_reg <= REG_WDATA & cic_pkg::POLARITY_BITS; // R7
			end
			if (wr_control) begin
				control_reg <= REG_WDATA & cic_pkg::CONTROL_BITS; // R4
			end
		end
	end

	// only the function field of each pin control word lives here
	genvar i;
	generate
		for (i = 0; i < cic_pkg::NUM_PINS; i++) begin : g_fn
			localparam logic [5:0] FN_RESET = (i == 3) ? cic_pkg::PIN4_FN_RESET :
				(i == 4) ? cic_pkg::PIN5_FN_RESET : PIN123_FN_RESET;
			assign pin_hit[i] = REG_ADDR == (cic_pkg::PIN1_FUNCTION_ADDR + 8'(i));
			always_ff @(posedge REF_CLK or posedge RESET) begin
				if (RESET) begin
					pin_fn_reg[i] <= FN_RESET; // R10
				end else if (REG_WR && pin_hit[i]) begin
					pin_fn_reg[i] <= REG_WDATA[cic_pkg::FN_LSB +: cic_pkg::FN_W]; // R10
				end
			end
		end
	endgenerate

	// ***************************************************************
	// interrupt output
	// ***************************************************************
	assign irq_raw      = |(status_reg & ~mask_reg); // R1
	assign irq_out_next = irq_raw ^ irq_output_invert; // R4

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			irq_out_reg <= 1'h0; // R4
		end else begin
			irq_out_reg <= irq_out_next;
		end
	end

	assign IRQ_OUT       = irq_out_reg;
	assign bus.irq_level = irq_out_reg;
	assign bus.pin_fn    = pin_fn_reg;
	assign PIN_IRQ_OUT   = bus.pin_out;
	assign PIN_IRQ_OE    = bus.pin_oe;

	cic_pin_route u_route (
		.clk   (REF_CLK),
		.reset (RESET),
		.bus   (bus.route)
	);

	// ***************************************************************
	// read path
	// ***************************************************************
	always_comb begin
		pin_fn_rd = 6'h00;
		for (int k = 0; k < cic_pkg::NUM_PINS; k++) begin
			if (pin_hit[k]) begin
				pin_fn_rd = pin_fn_reg[k];
			end
		end
	end

	// unmapped offsets read as zero
	assign rd_mux = hit_status   ? status_reg :
		hit_mask     ? mask_reg :
		hit_polarity ? polarity_reg :
		hit_control  ? control_reg :
		|pin_hit     ? {2'h0, pin_fn_rd, 8'h00} : 16'h0000;

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			rdata_reg  <= 16'h0000;
			rvalid_reg <= 1'h0;
		end else begin
			rvalid_reg <= REG_RD;
			if (REG_RD) begin
				rdata_reg <= rd_mux; // R13
			end
		end
	end

	assign REG_RDATA  = rdata_reg;
	assign REG_RVALID = rvalid_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	sequence s_read_status;
		REG_RD && hit_status;
	endsequence

	sequence s_read_short_active;
		s_read_status ##0 short_ev;
	endsequence

	property p_irq_or;
		1'h1 |=> IRQ_OUT == ($past(|(status_reg & ~mask_reg)) ^ $past(irq_output_invert));
	endproperty
	a_irq_or: assert property (p_irq_or) // R1
		else $error("interrupt output not the OR of unmasked flags");

	property p_latch;
		1'h1 |=> (status_reg & $past(set_vec)) == $past(set_vec);
	endproperty
	a_latch: assert property (p_latch) // R2
		else $error("active source did not latch its flag");

	property p_hold;
		!rd_status |=> (status_reg & $past(status_reg)) == $past(status_reg);
	endproperty
	a_hold: assert property (p_hold) // R2
		else $error("flag cleared without a status read");

	property p_reassert;
		s_read_short_active |=> status_reg[cic_pkg::BIAS_SHORT_BIT] ##1 IRQ_OUT
			== ($past(|(status_reg & ~mask_reg)) ^ $past(irq_output_invert));
	endproperty
	a_reassert: assert property (p_reassert) // R3
		else $error("still active source not set again after read");

	property p_polarity;
		$rose(irq_output_invert) && !$changed(irq_raw) |=> IRQ_OUT == !$past(irq_raw);
	endproperty
	a_polarity: assert property (p_polarity) // R4
		else $error("output polarity not inverted by control bit");

	property p_mask_write;
		wr_mask |=> mask_reg == ($past(REG_WDATA) & cic_pkg::EVENT_BITS);
	endproperty
	a_mask_write: assert property (p_mask_write) // R6
		else $error("mask register not written");

	property p_detector;
		(BIAS_CURRENT_DET != current_detect_invert) |=> status_reg[cic_pkg::BIAS_CURRENT_BIT];
	endproperty
	a_detector: assert property (p_detector) // R7
		else $error("current detector event missed");

	property p_seq_done;
		$fell(SEQ_BUSY) |=> status_reg[cic_pkg::SEQ_DONE_BIT];
	endproperty
	a_seq_done: assert property (p_seq_done) // R8
		else $error("sequencer finish not flagged");

	property p_pin_pol;
		(GPIO_IN[0] == PIN_INPUT_POLARITY[0]) |=> status_reg[cic_pkg::PIN_FLAG_LSB];
	endproperty
	a_pin_pol: assert property (p_pin_pol) // R9
		else $error("pin event ignored its input polarity");

	property p_read_clear;
		s_read_status |=> status_reg == ($past(set_vec) & cic_pkg::EVENT_BITS)
			&& REG_RVALID && REG_RDATA == $past(status_reg);
	endproperty
	a_read_clear: assert property (p_read_clear) // R13
		else $error("status read returned or cleared the wrong bits");

endmodule

// ### pkg/cic_pkg.sv
// constants of the codec interrupt controller: map, fields, resets
package cic_pkg;

	// ***************************************************************
	// register offsets
	// ***************************************************************
	localparam logic [7:0] PIN1_FUNCTION_ADDR      = 8'h74;
	localparam logic [7:0] EVENT_STATUS_ADDR       = 8'h79;
	localparam logic [7:0] EVENT_MASK_ADDR         = 8'h7a;
	localparam logic [7:0] DETECTOR_POLARITY_ADDR  = 8'h7b;
	localparam logic [7:0] IRQ_OUTPUT_CONTROL_ADDR = 8'h7e;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int NUM_PINS           = 5;
	localparam int BIAS_SHORT_BIT     = 15;
	localparam int BIAS_CURRENT_BIT   = 14;
	localparam int SEQ_DONE_BIT       = 13;
	localparam int PIN_FLAG_LSB       = 0;
	localparam int SHORT_INVERT_BIT   = 15;
	localparam int CURRENT_INVERT_BIT = 14;
	localparam int IRQ_INVERT_BIT     = 0;
	localparam int FN_LSB             = 8;
	localparam int FN_W               = 6;

	// ***************************************************************
	// implemented bits and reset values
	// ***************************************************************
	localparam logic [15:0] EVENT_BITS       = 16'he01f;
	localparam logic [15:0] POLARITY_BITS    = 16'hc000;
	localparam logic [15:0] CONTROL_BITS     = 16'h0001;
	localparam logic [15:0] STATUS_RESET     = 16'h0000;
	localparam logic [15:0] MASK_RESET       = 16'he01f;
	localparam logic [15:0] POLARITY_RESET   = 16'h0000;
	localparam logic [15:0] CONTROL_RESET    = 16'h0000;
	localparam logic [5:0]  PIN4_FN_RESET    = 6'h02;
	localparam logic [5:0]  PIN5_FN_RESET    = 6'h01;

	// ***************************************************************
	// pin function codes
	// ***************************************************************
	localparam logic [5:0]  FN_IRQ_OUTPUT    = 6'h02;

endpackage

// ### pkg/cic_if.sv
// carrier between the controller core and the pin router
`timescale 1ns/100ps
interface cic_if;
	logic            irq_level;
	logic [4:0][5:0] pin_fn;
	logic [4:0]      pin_out;
	logic [4:0]      pin_oe;

	modport ctrl  (output irq_level, output pin_fn, input pin_out, input pin_oe);
	modport route (input irq_level, input pin_fn, output pin_out, output pin_oe);
endinterface

// ### rtl/cic_pin_route.sv
// routes the interrupt level onto any pin whose function selects it
`timescale 1ns/100ps
module cic_pin_route (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// core side
	cic_if.route      bus
);

	logic [4:0] sel;
	logic [4:0] pin_out_reg;
	logic [4:0] pin_oe_reg;

	// ***************************************************************
	// per-pin selection
	// ***************************************************************
	genvar i;
	generate
		for (i = 0; i < cic_pkg::NUM_PINS; i++) begin : g_pin
			assign sel[i] = bus.pin_fn[i] == cic_pkg::FN_IRQ_OUTPUT; // R12 R10
		end
	endgenerate

	// registered so the pin never glitches while the selects change
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_out_reg <= 5'h00;
			pin_oe_reg  <= 5'h00;
		end else begin
			pin_oe_reg  <= sel;
			pin_out_reg <= sel & {5{bus.irq_level}};
		end
	end

	assign bus.pin_out = pin_out_reg;
	assign bus.pin_oe  = pin_oe_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	property p_route;
		@(posedge clk) disable iff (reset)
		(bus.pin_fn[3] == cic_pkg::FN_IRQ_OUTPUT)
			|=> bus.pin_oe[3] && (bus.pin_out[3] == $past(bus.irq_level));
	endproperty
	a_route: assert property (p_route) // R12
		else $error("routed pin does not carry the interrupt level");

	property p_unrouted;
		@(posedge clk) disable iff (reset)
		(bus.pin_fn[0] != cic_pkg::FN_IRQ_OUTPUT) |=> !bus.pin_oe[0] && !bus.pin_out[0];
	endproperty
	a_unrouted: assert property (p_unrouted) // R10
		else $error("pin driven without the interrupt function selected");

endmodule

// ### bench/cic_host_model.sv
// host side watching the interrupt pin
`timescale 1ns/100ps
module cic_host_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// pin and host setting
	input  wire logic       irq_pin,
	input  wire logic       active_low,
	// host view
	output logic            pending,
	output logic [7:0]      seen_count
);
	// host may poll status any time or react to this level
	assign pending = irq_pin ^ active_low;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seen_count <= 8'h00;
		end else if (pending) begin
			seen_count <= seen_count + 8'h01;
		end
	end
endmodule

// ### bench/codec_interrupt_controller_test.sv
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
module codec_interrupt_controller_test;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, pol, mask, ev, v;
	logic        reg_wr, reg_rd, reg_rvalid, bias_short, bias_current, seq_busy, irq_out;
	logic        ctl_inv, host_pending;
	logic [7:0]  host_seen, seen_mark;
	logic [4:0]  gpio_in, pin_pol, pin_irq_out, pin_irq_oe;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cycles = 0;

	always #4 ref_clk = ~ref_clk;

	cic_top cic_top_i (.REF_CLK(ref_clk), .RESET(reset), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.REG_RVALID(reg_rvalid), .GPIO_IN(gpio_in), .PIN_INPUT_POLARITY(pin_pol),
		.BIAS_SHORT_DET(bias_short), .BIAS_CURRENT_DET(bias_current), .SEQ_BUSY(seq_busy),
		.IRQ_OUT(irq_out), .PIN_IRQ_OUT(pin_irq_out), .PIN_IRQ_OE(pin_irq_oe));

	cic_host_model cic_host_model_i (.clk(ref_clk), .reset(reset), .irq_pin(pin_irq_out[3]),
		.active_low(ctl_inv), .pending(host_pending), .seen_count(host_seen));

	// ***************************************************************
	// helpers
	// ***************************************************************
	task automatic finish_test();
		if (err_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// generous ceiling: the run needs under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 8000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: value %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
	endtask

	// answer comes exactly one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		check({15'h0000, reg_rvalid}, 16'h0001);
		d = reg_rdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		check(d, e);
	endtask

	// every source at its inactive level
	task automatic quiet();
		gpio_in = ~pin_pol;
		bias_short = pol[15];
		bias_current = pol[14];
		seq_busy = 1'b0;
	endtask

	function automatic logic [15:0] exp_ev(input logic [4:0] g, input logic [4:0] p,
		input logic s, input logic c, input logic q, input logic [15:0] inv);
		exp_ev = 16'h0000;
		exp_ev[4:0] = ~(g ^ p);
		exp_ev[15] = s ^ inv[15];
		exp_ev[14] = c ^ inv[14];
		exp_ev[13] = q;
	endfunction

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		v = 16'($urandom(32'h1ca9));
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pol = 16'h0000;
		ctl_inv = 1'b0;
		pin_pol = 5'h1f;
		quiet();
		idle(12);
		reset = 1'b0;
		rdc(cic_pkg::EVENT_MASK_ADDR, 16'he01f);
		rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h0000);
		rdc(cic_pkg::DETECTOR_POLARITY_ADDR, 16'h0000);
		rdc(cic_pkg::IRQ_OUTPUT_CONTROL_ADDR, 16'h0000);
		rdc(8'h77, 16'h0200);
		rdc(8'h00, 16'h0000);
		check({11'h000, pin_irq_oe}, 16'h0008);
		// random sources, masks and polarities
		for (int i = 0; i < 40; i++) begin
			mask = 16'($urandom) & cic_pkg::EVENT_BITS;
			pol = 16'($urandom) & cic_pkg::POLARITY_BITS;
			pin_pol = 5'($urandom);
			wr(cic_pkg::EVENT_MASK_ADDR, mask);
			wr(cic_pkg::DETECTOR_POLARITY_ADDR, pol);
			quiet();
			idle(2);
			rd(cic_pkg::EVENT_STATUS_ADDR, v);
			gpio_in = 5'($urandom);
			bias_short = 1'($urandom);
			bias_current = 1'($urandom);
			seq_busy = 1'($urandom);
			ev = exp_ev(gpio_in, pin_pol, bias_short, bias_current, seq_busy, pol);
			idle(1);
			quiet();
			idle(5);
			check({15'h0000, irq_out}, {15'h0000, |(ev & ~mask)});
			check({15'h0000, pin_irq_out[3]}, {15'h0000, |(ev & ~mask)});
			rdc(cic_pkg::EVENT_STATUS_ADDR, ev);
			rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h0000);
		end
		// source still active across a read
		wr(cic_pkg::EVENT_MASK_ADDR, 16'h0000);
		gpio_in[2] = pin_pol[2];
		bias_short = ~pol[15];
		idle(3);
		rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h8004);
		rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h8004);
		idle(2);
		check({15'h0000, irq_out}, 16'h0001);
		// inverted output while the source stays active
		wr(cic_pkg::IRQ_OUTPUT_CONTROL_ADDR, 16'h0001);
		ctl_inv = 1'b1;
		idle(3);
		check({15'h0000, irq_out}, 16'h0000);
		check({15'h0000, host_pending}, 16'h0001);
		seen_mark = host_seen;
		idle(1);
		check({8'h00, host_seen}, {8'h00, seen_mark + 8'h01});
		rdc(cic_pkg::IRQ_OUTPUT_CONTROL_ADDR, 16'h0001);
		wr(cic_pkg::IRQ_OUTPUT_CONTROL_ADDR, 16'h0000);
		ctl_inv = 1'b0;
		// every pin can carry the interrupt
		for (int p = 0; p < 5; p++) begin
			wr(8'h74 + 8'(p), 16'h0200);
			idle(3);
			check({15'h0000, pin_irq_oe[p]}, 16'h0001);
			check({15'h0000, pin_irq_out[p]}, 16'h0001);
			if (p != 3) begin
				wr(8'h74 + 8'(p), (p == 4) ? 16'h0100 : 16'h0000);
			end
		end
		idle(2);
		check({11'h000, pin_irq_oe}, 16'h0008);
		quiet();
		idle(1);
		rd(cic_pkg::EVENT_STATUS_ADDR, v);
		// status is not writable
		wr(cic_pkg::EVENT_STATUS_ADDR, 16'hffff);
		rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h0000);
		// event landing in the cycle of the read survives it
		@(posedge ref_clk);
		#1;
		reg_addr = cic_pkg::EVENT_STATUS_ADDR;
		reg_rd = 1'b1;
		gpio_in[0] = pin_pol[0];
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		gpio_in[0] = ~pin_pol[0];
		check(reg_rdata, 16'h0000);
		rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h0001);
		// finished sequence is flagged once
		seq_busy = 1'b1;
		idle(2);
		seq_busy = 1'b0;
		idle(3);
		rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h2000);
		rdc(cic_pkg::EVENT_STATUS_ADDR, 16'h0000);
		idle(3);
		check({15'h0000, irq_out}, 16'h0000);
		finish_test();
	end
endmodule
